// *** bench/rhps_dn_model.sv ***
// downstream port model: attach, over-current switch, reset completion and remote wake
`timescale 1ns/1ps
module rhps_dn_model (
  input  wire logic clk,          // system clock
  input  wire logic nrst,         // async reset, active low
  input  wire logic attach,       // bench: device plugged in
  input  wire logic fault,        // bench: power switch reports over-current
  input  wire logic reset_req,    // bench: finish a port reset
  input  wire logic wake_req,     // bench: device wants to wake the host
  input  wire logic resume_drive, // host drives resume downstream
  output logic      connected,    // connect level toward the port
  output logic      overcur,      // over-current level toward the port
  output logic      reset_done,   // one-cycle reset completion
  output logic      remote_wake   // device resume signalling
);
  logic reset_req_reg;  // edge detect so one request gives one pulse

  // line levels follow the device; wake stops once the host takes over the bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      connected     <= 1'b0;
      overcur       <= 1'b0;
      reset_done    <= 1'b0;
      remote_wake   <= 1'b0;
      reset_req_reg <= 1'b0;
    end else begin
      connected     <= attach;
      overcur       <= fault;
      reset_req_reg <= reset_req;
      reset_done    <= reset_req && !reset_req_reg;
      remote_wake   <= wake_req && !resume_drive;
    end
  end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the root hub port suspend and over-current logic
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  logic        CLOCK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, CONNECTED, OVERCUR_IN, RESET_DONE;
  logic        HC_USB_RESUME, REMOTE_WAKE, PORT_SUSPENDED, RESUME_DRIVE, SUSP_CHG_SET, CSC_SET, UPSTREAM_WAKE;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic        attach, fault, reset_req, wake_req;
  int          err_total, num_checks, chg_cnt, csc_cnt, n;

  rhps_port #(.RESUME_TICKS(2), .TICK_DIV(4)) rhps_port_inst (.CLOCK(CLOCK), .NRST(NRST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CONNECTED(CONNECTED),
    .OVERCUR_IN(OVERCUR_IN), .RESET_DONE(RESET_DONE), .HC_USB_RESUME(HC_USB_RESUME),
    .REMOTE_WAKE(REMOTE_WAKE), .PORT_SUSPENDED(PORT_SUSPENDED), .RESUME_DRIVE(RESUME_DRIVE),
    .SUSP_CHG_SET(SUSP_CHG_SET), .CSC_SET(CSC_SET), .UPSTREAM_WAKE(UPSTREAM_WAKE));
  rhps_dn_model rhps_dn_model_inst (.clk(CLOCK), .nrst(NRST), .attach(attach), .fault(fault),
    .reset_req(reset_req), .wake_req(wake_req), .resume_drive(RESUME_DRIVE), .connected(CONNECTED),
    .overcur(OVERCUR_IN), .reset_done(RESET_DONE), .remote_wake(REMOTE_WAKE));

  // 100 MHz clock
  always #5 CLOCK = ~CLOCK;

  // count change-flag pulses; suspend must drop in the same cycle as its change flag
  always @(posedge CLOCK) begin
    if (CSC_SET === 1'b1) csc_cnt++;
    if (SUSP_CHG_SET === 1'b1) begin
      chg_cnt++;
      `CHK(PORT_SUSPENDED, 1'b0)
    end
  end

  task automatic stop_test;
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one classic wishbone cycle; waits for ack, never assumes its latency
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge CLOCK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'b11, we, adr, 4'hF, dat};
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 50);
    rd = WB_DAT_O;
    `CHK(WB_ACK_O, 1'b1)
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'b000;
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    `CHK(rd, exp)
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge CLOCK);
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    stop_test;
  end

  // main sequence
  initial begin
    {CLOCK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, HC_USB_RESUME} = 6'b000000;
    {WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
    {attach, fault, reset_req, wake_req} = 4'b1000;
    {err_total, num_checks, chg_cnt, csc_cnt} = '0;
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    cyc(2);
    rdchk(rhps_pkg::PORT_STATUS_OFS, 32'h0000_0001);
    fault <= 1'b1;
    cyc(3);
    rdchk(rhps_pkg::PORT_STATUS_OFS, 32'h0000_0009);
    wb(1'b1, rhps_pkg::PORT_CTRL_OFS, 32'h0000_0000);
    rdchk(rhps_pkg::PORT_STATUS_OFS, 32'h0000_0001);
    wb(1'b1, rhps_pkg::PORT_CTRL_OFS, 32'h0000_0001);
    fault <= 1'b0;
    // zero writes and a resume request while active change nothing
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0000);
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0008);
    cyc(3);
    `CHK(PORT_SUSPENDED, 1'b0)
    `CHK(RESUME_DRIVE, 1'b0)
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0004);
    cyc(2);
    `CHK(PORT_SUSPENDED, 1'b1)
    rdchk(rhps_pkg::PORT_STATUS_OFS, 32'h0000_0005);
    wake_req <= 1'b1;
    cyc(3);
    `CHK(UPSTREAM_WAKE, 1'b1)
    wake_req <= 1'b0;
    // three wake cycles seen while suspended; state field shows suspend
    rdchk(rhps_pkg::PORT_EVENT_OFS, 32'h0001_0003);
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0008);
    cyc(2);
    `CHK(RESUME_DRIVE, 1'b1)
    `CHK(PORT_SUSPENDED, 1'b1)
    for (n = 0; n < 60 && chg_cnt == 0; n++) @(posedge CLOCK);
    `CHK(chg_cnt, 1)
    rdchk(rhps_pkg::PORT_STATUS_OFS, 32'h0000_0001);
    // port reset completion aborts suspend without a suspend change
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0004);
    reset_req <= 1'b1;
    cyc(3);
    reset_req <= 1'b0;
    `CHK(PORT_SUSPENDED, 1'b0)
    // controller resume state aborts an ongoing resume
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0004);
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0008);
    HC_USB_RESUME <= 1'b1;
    cyc(2);
    HC_USB_RESUME <= 1'b0;
    `CHK(PORT_SUSPENDED, 1'b0)
    cyc(30);
    `CHK(RESUME_DRIVE, 1'b0)
    `CHK(chg_cnt, 1)
    // commands on a disconnected port raise connect change instead
    attach <= 1'b0;
    cyc(3);
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0004);
    cyc(2);
    `CHK(PORT_SUSPENDED, 1'b0)
    `CHK(csc_cnt, 1)
    wb(1'b1, rhps_pkg::PORT_STATUS_OFS, 32'h0000_0010);
    cyc(2);
    `CHK(csc_cnt, 2)
    rdchk(8'h0C, 32'h0000_0000);
    stop_test;
  end
endmodule

// *** hdl/rhps_pkg.sv ***
// package: offsets, field positions, reset values and timing for the root hub port suspend logic
package rhps_pkg;
  // register byte offsets
  localparam logic [7:0] PORT_STATUS_OFS  = 8'h00;  // port status word
  localparam logic [7:0] PORT_CTRL_OFS    = 8'h04;  // configuration: per-port over-current reporting enable
  localparam logic [7:0] PORT_EVENT_OFS   = 8'h08;  // remote wake counter and state
  // port status word field positions
  localparam int CCS_BIT        = 0;
  localparam int SUSPEND_BIT    = 2;
  localparam int OVERCUR_BIT    = 3;
  localparam int CSC_BIT        = 16;
  localparam int SUSP_CHG_BIT   = 18;
  localparam int RST_CHG_BIT    = 20;
  localparam int PORT_RESET_BIT = 4;   // set-reset command, decoded only to refuse it
  // control register field positions
  localparam int CTRL_PERPORT_BIT = 0;  // per-port over-current reporting enable
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // resume signalling interval
  localparam int RESUME_TIME_US = 20;
  localparam int CLOCK_MHZ      = 100;
  localparam int RESUME_CYCLES  = RESUME_TIME_US * CLOCK_MHZ;
  localparam int TICK_DIV       = 100;   // 1 us tick at 100 MHz
  // port state machine
  typedef enum logic [1:0] {
    RHPS_ACTIVE  = 2'b00,
    RHPS_SUSPEND = 2'b01,
    RHPS_RESUME  = 2'b10
  } rhps_state_type;
endpackage

// *** hdl/rhps_port.sv ***
// root hub port suspend and over-current logic with a classic wishbone slave
`timescale 1ns/1ps
module rhps_port #(
  parameter int RESUME_TICKS = rhps_pkg::RESUME_TIME_US,  // resume length in 1 us ticks
  parameter int TICK_DIV     = rhps_pkg::TICK_DIV         // clocks per tick
) (
  input  wire logic        CLOCK,         // 100 MHz clock
  input  wire logic        NRST,          // async reset, active low
  input  wire logic        WB_CYC_I,      // wishbone cycle
  input  wire logic        WB_STB_I,      // wishbone strobe
  input  wire logic        WB_WE_I,       // wishbone write enable
  input  wire logic [7:0]  WB_ADR_I,      // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,      // wishbone byte selects
  input  wire logic [31:0] WB_DAT_I,      // wishbone write data
  output logic      [31:0] WB_DAT_O,      // wishbone read data
  output logic             WB_ACK_O,      // wishbone acknowledge
  input  wire logic        CONNECTED,     // current connect status
  input  wire logic        OVERCUR_IN,    // over-current sense input
  input  wire logic        RESET_DONE,    // port reset completion pulse
  input  wire logic        HC_USB_RESUME, // controller entering resume state
  input  wire logic        REMOTE_WAKE,   // resume signalled by downstream device
  output logic             PORT_SUSPENDED,// suspend status to port logic
  output logic             RESUME_DRIVE,  // drive resume signalling downstream
  output logic             SUSP_CHG_SET,  // pulse: set suspend change flag
  output logic             CSC_SET,       // pulse: set connect status change flag
  output logic             UPSTREAM_WAKE  // high the cycle after each cycle a suspended port sees remote wake: resume propagated to controller
);
  rhps_pkg::rhps_state_type state_reg;
  logic        perport_reg;
  logic        port_overcurrent_flag;
  logic        tick;
  logic        timer_done;
  logic        bus_req;
  logic        wr_stb;
  logic        status_wr;
  logic        set_susp_wr;
  logic        clr_susp_wr;
  logic        set_reset_wr;
  logic        start_resume;
  logic        suspend_clear;
  logic [31:0] rd_next;
  logic [15:0] wake_cnt_reg;

  // byte-lane test for a write bit
  function automatic logic wr_bit(input logic [31:0] d, input logic [3:0] s, input int b);
    wr_bit = d[b] && s[b / 8];
  endfunction

  // wishbone request decode; ack is a single registered pulse
  assign bus_req      = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_stb       = bus_req && WB_WE_I;
  assign status_wr    = wr_stb && (WB_ADR_I == rhps_pkg::PORT_STATUS_OFS);
  assign set_susp_wr  = status_wr && wr_bit(WB_DAT_I, WB_SEL_I, rhps_pkg::SUSPEND_BIT);
  assign clr_susp_wr  = status_wr && wr_bit(WB_DAT_I, WB_SEL_I, rhps_pkg::OVERCUR_BIT);
  assign set_reset_wr = status_wr && wr_bit(WB_DAT_I, WB_SEL_I, rhps_pkg::PORT_RESET_BIT);

  // over-current view: zero when per-port reporting is off
  assign port_overcurrent_flag = perport_reg && OVERCUR_IN;

  // resume begins only from suspend; reset completion and hc resume win
  assign suspend_clear = RESET_DONE || HC_USB_RESUME;
  assign start_resume  = clr_susp_wr && (state_reg == rhps_pkg::RHPS_SUSPEND) && !suspend_clear;

  rhps_tick #(
    .DIV  (TICK_DIV)
  ) u_tick (
    .clk  (CLOCK),
    .nrst (NRST),
    .tick (tick)
  );

  rhps_timer #(
    .TICKS (RESUME_TICKS)
  ) u_timer (
    .clk   (CLOCK),
    .nrst  (NRST),
    .start (start_resume),
    .abort (suspend_clear),
    .tick  (tick),
    .done  (timer_done)
  );

  // port suspend state machine
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= rhps_pkg::RHPS_ACTIVE;
    end else if (suspend_clear) begin
      state_reg <= rhps_pkg::RHPS_ACTIVE;
    end else begin
      unique case (state_reg)
        rhps_pkg::RHPS_ACTIVE: begin
          if (set_susp_wr && CONNECTED) begin
            state_reg <= rhps_pkg::RHPS_SUSPEND;
          end
        end
        rhps_pkg::RHPS_SUSPEND: begin
          if (start_resume) begin
            state_reg <= rhps_pkg::RHPS_RESUME;
          end
        end
        rhps_pkg::RHPS_RESUME: begin
          if (timer_done) begin
            state_reg <= rhps_pkg::RHPS_ACTIVE;
          end
        end
        default: begin
          state_reg <= rhps_pkg::RHPS_ACTIVE;
        end
      endcase
    end
  end

  // registered port outputs; suspend stays high through resume
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PORT_SUSPENDED <= 1'b0;
      RESUME_DRIVE   <= 1'b0;
      SUSP_CHG_SET   <= 1'b0;
    end else begin
      PORT_SUSPENDED <= 1'b0;
      RESUME_DRIVE   <= 1'b0;
      SUSP_CHG_SET   <= 1'b0;
      if (suspend_clear) begin
        PORT_SUSPENDED <= 1'b0;
      end else if (state_reg == rhps_pkg::RHPS_RESUME && timer_done) begin
        SUSP_CHG_SET <= 1'b1;
      end else if (state_reg == rhps_pkg::RHPS_RESUME || start_resume) begin
        PORT_SUSPENDED <= 1'b1;
        RESUME_DRIVE   <= 1'b1;
      end else if (state_reg == rhps_pkg::RHPS_SUSPEND || (set_susp_wr && CONNECTED &&
                   state_reg == rhps_pkg::RHPS_ACTIVE)) begin
        PORT_SUSPENDED <= 1'b1;
      end
    end
  end

  // refused commands on a disconnected port report a connect change
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      CSC_SET <= 1'b0;
    end else begin
      CSC_SET <= !CONNECTED && (set_susp_wr || set_reset_wr);
    end
  end

  // remote wakeup on a suspended port goes upstream and counts
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      UPSTREAM_WAKE <= 1'b0;
      wake_cnt_reg  <= 16'h0000;
    end else begin
      UPSTREAM_WAKE <= REMOTE_WAKE && (state_reg == rhps_pkg::RHPS_SUSPEND);
      if (REMOTE_WAKE && state_reg == rhps_pkg::RHPS_SUSPEND) begin
        wake_cnt_reg <= wake_cnt_reg + 16'h0001;
      end
    end
  end

  // control register: per-port over-current reporting
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      perport_reg <= rhps_pkg::CTRL_RESET[rhps_pkg::CTRL_PERPORT_BIT];
    end else if (wr_stb && WB_ADR_I == rhps_pkg::PORT_CTRL_OFS && WB_SEL_I[0]) begin
      perport_reg <= WB_DAT_I[rhps_pkg::CTRL_PERPORT_BIT];
    end
  end

  // read mux; status bits reflect live state, writes never land here
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (WB_ADR_I)
      rhps_pkg::PORT_STATUS_OFS: begin
        rd_next[rhps_pkg::CCS_BIT]     = CONNECTED;
        rd_next[rhps_pkg::SUSPEND_BIT] = state_reg != rhps_pkg::RHPS_ACTIVE;
        rd_next[rhps_pkg::OVERCUR_BIT] = port_overcurrent_flag;
      end
      rhps_pkg::PORT_CTRL_OFS: begin
        rd_next[rhps_pkg::CTRL_PERPORT_BIT] = perport_reg;
      end
      rhps_pkg::PORT_EVENT_OFS: begin
        rd_next[15:0]  = wake_cnt_reg;
        rd_next[17:16] = state_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;  // unmapped reads zero, still acked
      end
    endcase
  end

  // ack one cycle after the request, every address answered
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= rd_next;
      end
    end
  end

  // check helpers, counted apart from the timer so a miscounting timer cannot vouch for itself
  logic [15:0] chk_ticks_reg;
  logic [15:0] chk_clocks_reg;

  // ticks and clocks spent in resume since the resume was started
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      chk_ticks_reg  <= 16'h0000;
      chk_clocks_reg <= 16'h0000;
    end else if (start_resume) begin
      chk_ticks_reg  <= 16'h0000;
      chk_clocks_reg <= 16'h0000;
    end else if (state_reg == rhps_pkg::RHPS_RESUME) begin
      chk_clocks_reg <= chk_clocks_reg + 16'h0001;
      if (tick) begin
        chk_ticks_reg <= chk_ticks_reg + 16'h0001;
      end
    end
  end

  // checks: resume interval, plus refusal, abort, over-current view, wake and ack checks
  resume_length_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state_reg == rhps_pkg::RHPS_RESUME && !suspend_clear && !timer_done) |=> PORT_SUSPENDED && RESUME_DRIVE)
    else $error("suspend dropped during resume");
  susp_clear_flag_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    SUSP_CHG_SET |-> !PORT_SUSPENDED && $past(state_reg) == rhps_pkg::RHPS_RESUME)
    else $error("suspend change flag without resume end");
  resume_start_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    start_resume |=> RESUME_DRIVE && PORT_SUSPENDED && state_reg == rhps_pkg::RHPS_RESUME)
    else $error("resume request not started");
  resume_ticks_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (timer_done && state_reg == rhps_pkg::RHPS_RESUME) |-> chk_ticks_reg == 16'(RESUME_TICKS))
    else $error("resume interval tick count wrong");
  resume_clocks_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (timer_done && state_reg == rhps_pkg::RHPS_RESUME) |->
      (chk_clocks_reg > 16'((RESUME_TICKS - 1) * TICK_DIV) && chk_clocks_reg <= 16'(RESUME_TICKS * TICK_DIV)))
    else $error("resume interval length wrong");
  chg_follows_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    SUSP_CHG_SET |-> $past(PORT_SUSPENDED))
    else $error("suspend change flag without suspend before it");
  drive_view_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    RESUME_DRIVE |-> PORT_SUSPENDED)
    else $error("resume driven while suspend status low");
  no_susp_disc_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (set_susp_wr && !CONNECTED && state_reg == rhps_pkg::RHPS_ACTIVE) |=> state_reg == rhps_pkg::RHPS_ACTIVE)
    else $error("suspend set on disconnected port");
  csc_on_refuse_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (set_susp_wr && !CONNECTED) |=> CSC_SET)
    else $error("connect change missing");
  reset_clear_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    RESET_DONE |=> !PORT_SUSPENDED && state_reg == rhps_pkg::RHPS_ACTIVE)
    else $error("suspend kept after port reset");
  hc_resume_clear_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    HC_USB_RESUME |=> state_reg == rhps_pkg::RHPS_ACTIVE)
    else $error("suspend kept in controller resume");
  resume_gate_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (clr_susp_wr && state_reg == rhps_pkg::RHPS_ACTIVE) |=> !RESUME_DRIVE)
    else $error("resume started without suspend");
  overcur_view_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    !perport_reg |-> !port_overcurrent_flag)
    else $error("over-current shown without per-port reporting");
  wake_prop_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (REMOTE_WAKE && state_reg == rhps_pkg::RHPS_SUSPEND) |=> UPSTREAM_WAKE)
    else $error("remote wake not propagated");
  ack_pulse_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");

  // checks: suspend entry, refusals and aborts
  set_suspend_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (set_susp_wr && CONNECTED && state_reg == rhps_pkg::RHPS_ACTIVE && !suspend_clear) |=>
      (PORT_SUSPENDED && state_reg == rhps_pkg::RHPS_SUSPEND))
    else $error("suspend request not taken");
  suspend_stays_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state_reg == rhps_pkg::RHPS_SUSPEND && !suspend_clear) |=> PORT_SUSPENDED && state_reg != rhps_pkg::RHPS_ACTIVE)
    else $error("suspend left without a clearing event");
  zero_write_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (status_wr && !wr_bit(WB_DAT_I, WB_SEL_I, rhps_pkg::SUSPEND_BIT) && !wr_bit(WB_DAT_I, WB_SEL_I,
      rhps_pkg::OVERCUR_BIT) && !suspend_clear && !timer_done) |=> $stable(state_reg))
    else $error("zero write changed port state");
  idle_no_resume_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_reg == rhps_pkg::RHPS_ACTIVE |=> !RESUME_DRIVE)
    else $error("resume driven from active port");
  csc_reset_refuse_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (set_reset_wr && !CONNECTED) |=> CSC_SET)
    else $error("connect change missing on refused reset");
  csc_cause_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    CSC_SET |-> !$past(CONNECTED))
    else $error("connect change on a connected port");
  abort_no_flag_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    suspend_clear |=> !SUSP_CHG_SET && !RESUME_DRIVE && !PORT_SUSPENDED)
    else $error("aborted suspend left outputs active");

  // checks: over-current view, wake path and register bus
  overcur_follow_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    perport_reg |-> port_overcurrent_flag == OVERCUR_IN)
    else $error("over-current view does not follow input");
  ctrl_write_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (wr_stb && WB_ADR_I == rhps_pkg::PORT_CTRL_OFS && WB_SEL_I[0]) |=> perport_reg == $past(WB_DAT_I[0]))
    else $error("reporting enable not written");
  status_read_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == rhps_pkg::PORT_STATUS_OFS) |->
      (WB_DAT_O[rhps_pkg::OVERCUR_BIT] == ($past(perport_reg) && $past(OVERCUR_IN)) &&
       WB_DAT_O[rhps_pkg::SUSPEND_BIT] == ($past(state_reg) != rhps_pkg::RHPS_ACTIVE)))
    else $error("status read does not show live state");
  event_read_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == rhps_pkg::PORT_EVENT_OFS) |->
      WB_DAT_O[17:16] == $past(state_reg))
    else $error("event read does not show state");
  unmapped_read_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) != rhps_pkg::PORT_STATUS_OFS &&
      $past(WB_ADR_I) != rhps_pkg::PORT_CTRL_OFS && $past(WB_ADR_I) != rhps_pkg::PORT_EVENT_OFS) |->
      WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  write_keeps_data_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WB_ACK_O && $past(WB_WE_I)) |-> $stable(WB_DAT_O))
    else $error("write loaded the read data");
  wake_idle_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_reg != rhps_pkg::RHPS_SUSPEND |=> !UPSTREAM_WAKE)
    else $error("wake propagated from a port not suspended");
  wake_count_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    (REMOTE_WAKE && state_reg == rhps_pkg::RHPS_SUSPEND) |=> wake_cnt_reg == $past(wake_cnt_reg) + 16'h0001)
    else $error("remote wake not counted");
  ack_answer_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    bus_req |=> WB_ACK_O)
    else $error("request not acknowledged");
  ack_cause_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without a request");

  // covers for the main scenarios
  suspend_c: cover property (@(posedge CLOCK) disable iff (!NRST) set_susp_wr && CONNECTED);
  resume_end_c: cover property (@(posedge CLOCK) disable iff (!NRST) SUSP_CHG_SET);
  refused_c: cover property (@(posedge CLOCK) disable iff (!NRST) CSC_SET);
  wake_c: cover property (@(posedge CLOCK) disable iff (!NRST) UPSTREAM_WAKE);
  abort_c: cover property (@(posedge CLOCK) disable iff (!NRST) suspend_clear && state_reg != rhps_pkg::RHPS_ACTIVE);
endmodule

// *** hdl/rhps_tick.sv ***
// divider that produces a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module rhps_tick #(
  parameter int DIV = rhps_pkg::TICK_DIV
) (
  input  wire logic clk,     // system clock
  input  wire logic nrst,    // async reset, active low
  output logic      tick     // one-cycle enable
);
  logic [15:0] cnt_reg;

  // free-running count, wraps at DIV
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      tick <= (cnt_reg == 16'(DIV - 1));
      if (cnt_reg == 16'(DIV - 1)) begin
        cnt_reg <= 16'h0000;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule

// *** hdl/rhps_timer.sv ***
// resume interval timer counting enable ticks
`timescale 1ns/1ps
module rhps_timer #(
  parameter int TICKS = rhps_pkg::RESUME_TIME_US
) (
  input  wire logic clk,     // system clock
  input  wire logic nrst,    // async reset, active low
  input  wire logic start,   // load and run
  input  wire logic abort,   // stop without finishing
  input  wire logic tick,    // counting enable
  output logic      done     // one-cycle end pulse
);
  logic [15:0] cnt_reg;
  logic        run_reg;

  // count ticks while running, pulse done on the last one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        run_reg <= 1'b0;
      end else if (start) begin
        cnt_reg <= 16'(TICKS);
        run_reg <= 1'b1;
      end else if (run_reg && tick) begin
        if (cnt_reg <= 16'h0001) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule
